/* File: rtl/acs_pkg.sv */
// Shared constants and types for the conversion sequencer.
package acs_pkg;
    // ============================================================
    // Widths and depths
    localparam int DATA_W     = 20;
    localparam int FIFO_DEPTH = 16;
    localparam int MODE_W     = 2;
    localparam int RES_W      = 5;
    // ============================================================
    // Priming: three conversions fill the decimator pipeline.
    localparam logic [1:0] PRIME_N   = 2'h3;
    localparam logic [1:0] PRIME_OFF = 2'h0;
    // ============================================================
    // Operating modes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_CONT   = 2'h1;
    localparam logic [1:0] MODE_MULTI  = 2'h2;
    localparam logic [1:0] MODE_TURBO  = 2'h3;
    // ============================================================
    // Resolution limits for turbo behaviour
    localparam logic [4:0] RES_TURBO_MIN = 5'h11;
    localparam logic [4:0] RES_TURBO_MAX = 5'h14;
    // ============================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_CLR  = 3'h2,
        ST_RUN  = 3'h4
    } acs_state_t;
    typedef struct packed {
        logic [MODE_W-1:0] mode;
        logic [RES_W-1:0]  res;
    } acs_cfg_t;
    localparam acs_cfg_t CFG_RST = '{mode: 2'h0, res: 5'h10};
endpackage : acs_pkg

/* File: rtl/acs_sequencer.sv */
// Conversion sequencer for a delta-sigma converter with its result FIFO.
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Result FIFO
module acs_fifo #(
    parameter int W = 20,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic [AW-1:0] next_wp;
    logic [AW-1:0] next_rp;
    logic [AW:0]   next_cnt;
    logic          wr;
    logic          rd;

    always_comb begin
        in_ready  = (cnt != (AW+1)'(D));
        out_valid = (cnt != '0);
        out_data  = mem[rp];
        wr        = in_valid & in_ready;
        rd        = out_valid & out_ready;
        next_wp   = wr ? wp + 1'b1 : wp;
        next_rp   = rd ? rp + 1'b1 : rp;
        next_cnt  = cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            wp  <= next_wp;
            rp  <= next_rp;
            cnt <= next_cnt;
        end
    end

    // Storage carries no reset so it can map onto plain memory.
    always_ff @(posedge clk) begin
        if (wr) begin
            mem[wp] <= in_data;
        end
    end
endmodule : acs_fifo

// ============================================================
// Sequencer top
module acs_sequencer
    import acs_pkg::*;
(
    // Clock and reset
    input  wire logic              MCLK,
    input  wire logic              RSTN,
    // Control and configuration
    input  wire logic              START_SW,
    input  wire logic              SOC,
    input  wire logic              STOP,
    input  wire logic              MUX_CHG,
    input  wire logic [MODE_W-1:0] MODE,
    input  wire logic [RES_W-1:0]  RES,
    // Decimator side
    input  wire logic              DEC_VALID,
    input  wire logic [DATA_W-1:0] DEC_DATA,
    output logic                   DEC_CLR,
    output logic                   DEC_RUN,
    output logic                   DEC_HOLD,
    // Reader side
    input  wire logic              RD,
    output logic [DATA_W-1:0]      RESULT,
    output logic                   EOC,
    output logic                   STATUS_DONE,
    // Status
    output logic                   BUSY,
    output logic                   OVERRUN
);
    // ============================================================
    // Sequencer state
    acs_state_t  state;
    acs_state_t  next_state;
    acs_cfg_t    cfg;
    acs_cfg_t    next_cfg;
    logic [1:0]  prime;
    logic [1:0]  next_prime;
    logic        next_clr;
    logic        next_run;
    logic        next_busy;
    logic        next_ovr;
    logic        start;
    logic        result;
    logic        push;
    logic        turbo_hi;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [DATA_W-1:0] fifo_out_data;

    assign start    = START_SW | SOC;
    assign turbo_hi = (cfg.mode == MODE_TURBO) && (cfg.res >= RES_TURBO_MIN) && (cfg.res <= RES_TURBO_MAX);
    // A stop or an input change in the same cycle wins, so that word must never reach the FIFO.
    assign result   = (state == ST_RUN) && DEC_VALID && (prime == PRIME_OFF) && !STOP && !MUX_CHG;
    assign push     = result & fifo_in_ready;

    always_comb begin
        next_state = state;
        next_cfg   = cfg;
        next_prime = prime;
        next_ovr   = OVERRUN;
        case (state)
            ST_IDLE: begin
                // Nothing runs until software or the trigger starts it.
                if (start) begin
                    next_cfg   = '{mode: MODE, res: RES};
                    next_ovr   = 1'b0;
                    next_state = ST_CLR;
                end
            end
            ST_CLR: begin
                if (STOP) begin
                    next_state = ST_IDLE;
                end else begin
                    next_prime = PRIME_N;
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (STOP) begin
                    next_state = ST_IDLE;
                end else if (MUX_CHG) begin
                    next_prime = PRIME_N;
                end else if (DEC_VALID) begin
                    if (prime != PRIME_OFF) begin
                        next_prime = prime - 2'h1;
                    end else begin
                        if (!fifo_in_ready) begin
                            next_ovr = 1'b1;
                        end
                        case (cfg.mode)
                            MODE_SINGLE: next_state = ST_IDLE;
                            MODE_CONT:   next_state = ST_RUN;
                            MODE_MULTI:  next_state = ST_CLR;
                            MODE_TURBO:  next_state = turbo_hi ? ST_RUN : ST_CLR;
                            default:     next_state = ST_IDLE;
                        endcase
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
        next_clr  = (next_state == ST_CLR);
        next_run  = (next_state == ST_RUN);
        next_busy = (next_state != ST_IDLE);
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state   <= ST_IDLE;
            cfg     <= CFG_RST;
            prime   <= PRIME_OFF;
            DEC_CLR <= 1'b0;
            DEC_RUN <= 1'b0;
            BUSY    <= 1'b0;
            OVERRUN <= 1'b0;
        end else begin
            state   <= next_state;
            cfg     <= next_cfg;
            prime   <= next_prime;
            DEC_CLR <= next_clr;
            DEC_RUN <= next_run;
            BUSY    <= next_busy;
            OVERRUN <= next_ovr;
        end
    end

    // ============================================================
    // Result buffering
    // A full FIFO raises the hold request; a result that still arrives is lost and flagged.
    acs_fifo #(
        .W (DATA_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (MCLK),
        .rst_n     (RSTN),
        .in_valid  (result),
        .in_ready  (fifo_in_ready),
        .in_data   (DEC_DATA),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // ============================================================
    // Output stage and done flag
    logic              next_eoc;
    logic              next_hold;
    logic [DATA_W-1:0] next_result;

    assign fifo_out_ready = !EOC | RD;

    always_comb begin
        next_result = RESULT;
        next_eoc    = EOC;
        next_hold   = !fifo_in_ready;
        // A load in the same cycle as a read keeps the flag set.
        if (fifo_out_valid && fifo_out_ready) begin
            next_result = fifo_out_data;
            next_eoc    = 1'b1;
        end else if (RD) begin
            next_eoc = 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            RESULT      <= '0;
            EOC         <= 1'b0;
            STATUS_DONE <= 1'b0;
            DEC_HOLD    <= 1'b0;
        end else begin
            RESULT      <= next_result;
            EOC         <= next_eoc;
            STATUS_DONE <= next_eoc;
            DEC_HOLD    <= next_hold;
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    sequence seq_clear;
        state == ST_CLR;
    endsequence
    sequence seq_primed_run;
        state == ST_RUN && prime == PRIME_N;
    endsequence
    sequence seq_halted;
        state == ST_IDLE;
    endsequence

    a_idle_wait: assert property (state == ST_IDLE && !start |=> state == ST_IDLE)
        else $error("Sequencer left idle without a start.");
    a_start_go: assert property (state == ST_IDLE && start |=> seq_clear ##1 seq_primed_run)
        else $error("Start did not clear and prime the decimator.");
    a_prime_nopush: assert property (state == ST_RUN && prime != PRIME_OFF |-> !push)
        else $error("Result pushed during priming.");
    a_single_done: assert property (push && cfg.mode == MODE_SINGLE |-> ##[1:20] EOC)
        else $error("Done flag missing after single result.");
    a_single_idle: assert property (result && !STOP && cfg.mode == MODE_SINGLE |=> state == ST_IDLE)
        else $error("Single mode did not return to idle.");
    a_done_mirror: assert property (EOC == STATUS_DONE)
        else $error("Status bit and done output differ.");
    a_cont_stay: assert property (result && !STOP && !MUX_CHG && cfg.mode == MODE_CONT
        |=> state == ST_RUN && prime == PRIME_OFF)
        else $error("Continuous mode reprimed.");
    a_multi_reprime: assert property (result && !STOP && !MUX_CHG && cfg.mode == MODE_MULTI
        |=> seq_clear ##1 (seq_primed_run or seq_halted))
        else $error("Multi mode did not reprime.");
    a_turbo_fast: assert property (result && !STOP && !MUX_CHG && turbo_hi |=> state == ST_RUN)
        else $error("High resolution turbo reprimed.");
    a_eoc_hold: assert property (EOC && !RD |=> EOC && $stable(RESULT))
        else $error("Done flag dropped before read.");
    a_mux_reprime: assert property (state == ST_RUN && MUX_CHG && !STOP |=> prime == PRIME_N)
        else $error("Input change did not restart priming.");
    a_stop_nopush: assert property (STOP || MUX_CHG |-> !push)
        else $error("Result queued despite stop or input change.");
    a_cfg_hold: assert property (state != ST_IDLE && next_state != ST_IDLE |=> $stable(cfg))
        else $error("Configuration changed mid sequence.");
endmodule : acs_sequencer

`default_nettype wire

/* File: test/acs_dec_model.sv */
// Behavioural decimator that answers the sequencer with paced conversion words.
`timescale 1ns/1ns
`default_nettype none
module acs_dec_model
    import acs_pkg::*;
(
    // Clock
    input  wire logic              MCLK,
    // Sequencer control
    input  wire logic              DEC_CLR,
    input  wire logic              DEC_RUN,
    // Conversion words
    output logic                   DEC_VALID,
    output logic [DATA_W-1:0]      DEC_DATA
);
    int seed = 32'h114a_9f87;
    // ============================================================
    // Conversion pacing
    // A gap of two or more cycles keeps words clear of the reprime cycle.
    initial begin
        DEC_VALID = 1'b0;
        DEC_DATA  = '0;
        forever begin
            repeat (2 + ($unsigned($random(seed)) % 4)) @(posedge MCLK);
            #1;
            if (DEC_RUN && !DEC_CLR) begin
                DEC_DATA  = $random(seed);
                DEC_VALID = 1'b1;
                @(posedge MCLK);
                #1;
                DEC_VALID = 1'b0;
                DEC_DATA  = ~DEC_DATA;
            end
        end
    end
endmodule : acs_dec_model
`default_nettype wire

/* File: test/test_acs_sequencer.sv */
// Self-checking bench for the conversion sequencer and its result FIFO.
`timescale 1ns/1ns
`default_nettype none
module test_acs_sequencer
    import acs_pkg::*;
;
    logic              MCLK, RSTN, START_SW, SOC, STOP, MUX_CHG, RD, rd_en, live;
    logic [MODE_W-1:0] MODE;
    logic [RES_W-1:0]  RES;
    logic              DEC_VALID, DEC_CLR, DEC_RUN, DEC_HOLD, EOC, STATUS_DONE, BUSY, OVERRUN;
    logic [DATA_W-1:0] DEC_DATA, RESULT;
    logic [DATA_W-1:0] q[$];
    acs_cfg_t          cfg;
    int                seed = 32'h114a_9f87;
    int                bad_count, n_checks, n_res, pc;
    localparam logic [1:0] TM [5] = '{MODE_CONT, MODE_MULTI, MODE_TURBO, MODE_TURBO, MODE_TURBO};
    localparam logic [4:0] TR [5] = '{5'h10, 5'h0c, 5'h10, 5'h14, 5'h08};
    acs_sequencer uut (.MCLK(MCLK), .RSTN(RSTN), .START_SW(START_SW), .SOC(SOC), .STOP(STOP),
        .MUX_CHG(MUX_CHG), .MODE(MODE), .RES(RES), .DEC_VALID(DEC_VALID), .DEC_DATA(DEC_DATA),
        .DEC_CLR(DEC_CLR), .DEC_RUN(DEC_RUN), .DEC_HOLD(DEC_HOLD), .RD(RD), .RESULT(RESULT),
        .EOC(EOC), .STATUS_DONE(STATUS_DONE), .BUSY(BUSY), .OVERRUN(OVERRUN));
    acs_dec_model dec (.MCLK(MCLK), .DEC_CLR(DEC_CLR), .DEC_RUN(DEC_RUN), .DEC_VALID(DEC_VALID),
        .DEC_DATA(DEC_DATA));
    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end
    // ============================================================
    // Helpers
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic print_verdict();
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask : cyc
    task automatic until_ok(input string what, input int lim, ref int n, input int k);
        int t;
        t = 0;
        while (n < k && t < lim) begin
            START_SW = (cfg.mode == MODE_MULTI) && $random(seed);
            cyc(1);
            t++;
        end
        START_SW = 1'b0;
        if (t >= lim) begin
            chk(what, 1'b0, 1'b1);
            print_verdict();
        end
    endtask : until_ok
    task automatic start(input logic [1:0] m, input logic [4:0] r, input logic use_soc);
        MODE     = m;
        RES      = r;
        SOC      = use_soc;
        START_SW = !use_soc;
        cyc(1);
        {SOC, START_SW} = 2'b00;
        MODE = m + 2'h1;
        RES  = 5'h08 + RES_W'($unsigned($random(seed)) % 13);
    endtask : start
    task automatic stop_drain();
        int idle;
        STOP = 1'b1;
        cyc(1);
        STOP  = 1'b0;
        rd_en = 1'b1;
        idle  = 0;
        while (BUSY && idle < 200) begin
            cyc(1);
            idle++;
        end
        chk("busy", BUSY, 1'b0);
        if (BUSY) print_verdict();
        repeat (600) begin
            if (q.size() != 0 || EOC) cyc(1);
        end
        chk("drained", {EOC, q.size() == 0}, 2'b01);
    endtask : stop_drain
    always @(posedge MCLK) begin
        #1;
        RD = rd_en & $random(seed);
    end
    // ============================================================
    // Expected result stream, worked out from the mode rules
    always @(posedge MCLK) begin
        if (RSTN) begin
            chk("status bit", STATUS_DONE, EOC);
            if (RD && EOC && q.size() == 0) chk("extra result", EOC, 1'b0);
            else if (RD && EOC) chk("result", RESULT, q.pop_front());
            if (!BUSY && (START_SW || SOC)) begin
                cfg  = '{mode: MODE, res: RES};
                pc   = 0;
                live = 1'b1;
            end else if (live && STOP) begin
                live = 1'b0;
            end else if (live && MUX_CHG) begin
                pc = 0;
            end else if (live && DEC_VALID && pc < 3) begin
                pc++;
            end else if (live && DEC_VALID) begin
                n_res++;
                if (q.size() < FIFO_DEPTH + 1) q.push_back(DEC_DATA);
                if (cfg.mode == MODE_SINGLE) live = 1'b0;
                if (cfg.mode == MODE_MULTI || (cfg.mode == MODE_TURBO && cfg.res < RES_TURBO_MIN)) pc = 0;
            end
        end
    end
    // ============================================================
    // Main sequence
    initial begin
        {RSTN, START_SW, SOC, STOP, MUX_CHG, rd_en, live} = '0;
        MODE = MODE_SINGLE;
        RES  = 5'h10;
        repeat (10) @(posedge MCLK);
        #1;
        RSTN = 1'b1;
        chk("reset", {BUSY, EOC, DEC_RUN, OVERRUN, RESULT}, 0);
        start(MODE_SINGLE, 5'h10, 1'b1);
        until_ok("single", 400, n_res, 1);
        cyc(2);
        chk("single done", {BUSY, EOC, RESULT}, {2'b01, q[0]});
        cyc(20);
        chk("standby", {DEC_RUN, BUSY, EOC, n_res[3:0]}, 7'h11);
        stop_drain();
        // Continuous first, with the trigger left low and no input switching.
        for (int i = 0; i < 5; i++) begin
            start(TM[i], TR[i], i[0]);
            until_ok("run", 1500, n_res, n_res + 5);
            MUX_CHG = (i > 0);
            cyc(1);
            MUX_CHG = 1'b0;
            until_ok("rerun", 1500, n_res, n_res + 4);
            stop_drain();
        end
        rd_en = 1'b0;
        start(MODE_CONT, 5'h14, 1'b0);
        until_ok("fill", 2000, n_res, n_res + FIFO_DEPTH + 2);
        cyc(3);
        chk("fifo full", {DEC_HOLD, OVERRUN}, 2'b11);
        stop_drain();
        start(MODE_CONT, 5'h10, 1'b0);
        chk("clear pulse", {DEC_CLR, BUSY, DEC_RUN}, 3'b110);
        cyc(2);
        chk("overrun cleared", OVERRUN, 1'b0);
        stop_drain();
        print_verdict();
    end
endmodule : test_acs_sequencer
`default_nettype wire
